//--- dsam_defines.svh
`ifndef DSAM_DEFINES_SVH
`define DSAM_DEFINES_SVH
// Summary of operation
// R1 - Host first sets sample period word to one, giving 819.2 samples per second.
// R2 - Host sets range filter word for four-tap averaging and widest gyro range.
// R3 - Manual stimulus bits 10 apply negative stimulus; host waits 50 ms per change.
// R4 - Manual stimulus bits 01 apply positive stimulus; host ends by zeroing upper byte.
// R5 - Memory test bit starts a checksum check over the flash locations.
// R6 - Checksum result lands in flag bit 6, one meaning fail.
// R7 - Each completed read of the flag word clears all error flags.
// R8 - A persisting error sets its flag again at the next sample cycle.
// R9 - Supply flags 1 and 0 clear themselves once supply is back in range.
// R10 - Bits 15..13 flag accel, 12..10 gyro self-test failures, z y x order.
// R11 - Bits 9 and 8 read one while alarm two or one is active.
// R12 - Bits 5..2 flag self-test error, overrange, serial failure, flash update failure.
// R13 - Bit 1 reads one while the supply monitor reports above 5.25 V.
// R14 - Bit 0 reads one while the supply monitor reports below 4.75 V.
// R15 - Two independent alarms, each with threshold and sample-count registers.
// R16 - Threshold bit 15 picks greater-than when one, less-than when zero.
// R17 - Threshold bits 13..0 hold the limit, bit 14 unused, reset zero.
// R18 - Rate-of-change period is sample count times the sample period.
// R19 - Sample count in bits 7..0; zero and one both mean one sample.
// R20 - Internal self-test bit self-clears when done and reports per-sensor results.
// R21 - Memory test bit self-clears when the checksum test completes.
// R22 - Alarm control carries source selects: alarm two 15..12, alarm one 11..8.
// R23 - An error arriving with a clearing read stays set.
// R24 - Alarms are evaluated once per sample cycle from source, direction, threshold.

// ----------------------------------------
// Register word indexes (byte address / 2)
// ----------------------------------------
`define DSAM_IDX_MAG1  6'h10
`define DSAM_IDX_MAG2  6'h11
`define DSAM_IDX_SMP1  6'h12
`define DSAM_IDX_SMP2  6'h13
`define DSAM_IDX_ACTL  6'h14
`define DSAM_IDX_MSC   6'h1A
`define DSAM_IDX_PRD   6'h1B
`define DSAM_IDX_AVG   6'h1C
`define DSAM_IDX_DIAG  6'h1E

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define DSAM_RST_MSC   16'h0006
`define DSAM_RST_PRD   16'h0001
`define DSAM_RST_AVG   16'h0402
`define DSAM_RST_ZERO  16'h0000
`define DSAM_MAG_MASK  16'hBFFF
`define DSAM_SMP_MASK  16'h00FF
`define DSAM_DIAG_KEEP 16'hFC7F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSAM_MSC_MEM   11
`define DSAM_MSC_SELF  10
`define DSAM_MSC_NEG   9
`define DSAM_MSC_POS   8
`define DSAM_MAG_GT    15
`define DSAM_ACTL_ROC  6
`define DSAM_DG_FLASH  6
`define DSAM_DG_STERR  5
`define DSAM_DG_OVR    4
`define DSAM_DG_SPI    3
`define DSAM_DG_UPD    2
`define DSAM_DG_HIGH   1
`define DSAM_DG_LOW    0
`define DSAM_SRC_LAST  4'hB
`define DSAM_FRAME_BITS 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define DSAM_CLK_HZ        64'd200000000
`define DSAM_PRD1_SPS_X10  64'd8192
`define DSAM_BASE_CYCLES   ((`DSAM_CLK_HZ * 64'd10) / (`DSAM_PRD1_SPS_X10 * 64'd2))
`define DSAM_SELFTEST_US   64'd1000
`define DSAM_SELFTEST_CYC  ((`DSAM_CLK_HZ * `DSAM_SELFTEST_US) / 64'd1000000)
`endif

//--- dsam_pkg.sv
package dsam_pkg;
  typedef struct packed {
    logic [2:0] accel_fail;
    logic [2:0] gyro_fail;
    logic       selftest_err;
    logic       overrange;
    logic       flash_upd_fail;
    logic       supply_high;
    logic       supply_low;
  } dsam_cond_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } dsam_spi_in_t;

  typedef struct packed {
    logic auto_run;
    logic neg;
    logic pos;
  } dsam_stim_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'h0,
    TS_MEM  = 2'h1,
    TS_SELF = 2'h2
  } dsam_test_t;
endpackage

//--- dsam_monitor.sv
`timescale 1ns/1ps
`include "dsam_defines.svh"
module dsam_monitor
  import dsam_pkg::*;
#(
  parameter int BASE_CYCLES     = int'(`DSAM_BASE_CYCLES),
  parameter int SELFTEST_CYCLES = int'(`DSAM_SELFTEST_CYC),
  parameter int FLASH_AW        = 6
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Serial register port, mode 3
  input  wire dsam_spi_in_t       spi_in,
  output logic                    spi_miso,
  // Sensor conditions and alarm sources
  input  wire dsam_cond_t         cond,
  input  wire logic [15:0][13:0]  alarm_src,
  // Flash read port, one cycle latency
  output logic [FLASH_AW-1:0]     flash_addr,
  input  wire logic [15:0]        flash_data,
  // Self-test stimulus
  output dsam_stim_t              stim
);
  localparam int NW = 1 << FLASH_AW;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  function automatic logic signed [15:0] sx(input logic [13:0] v);
    sx = 16'(signed'(v));
  endfunction

  function automatic logic hit(input logic signed [15:0] v, input logic [15:0] thr);
    hit = thr[`DSAM_MAG_GT] ? (v > sx(thr[13:0])) : (v < sx(thr[13:0])); // R16 R17
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Sclk is sampled, so it must stay well below a quarter of clk
  dsam_spi_in_t spi_s1_reg, spi_s2_reg;
  dsam_cond_t   cond_s1_reg, cond_s2_reg;
  logic         sclk_d_reg, cs_d_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      spi_s1_reg  <= 3'h6;
      spi_s2_reg  <= 3'h6;
      sclk_d_reg  <= 1'h1;
      cs_d_reg    <= 1'h1;
      cond_s1_reg <= '0;
      cond_s2_reg <= '0;
    end else begin
      spi_s1_reg  <= spi_in;
      spi_s2_reg  <= spi_s1_reg;
      sclk_d_reg  <= spi_s2_reg.sclk;
      cs_d_reg    <= spi_s2_reg.cs_n;
      cond_s1_reg <= cond;
      cond_s2_reg <= cond_s1_reg;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = spi_s2_reg.sclk & ~sclk_d_reg;
  assign sclk_fall = ~spi_s2_reg.sclk & sclk_d_reg;
  assign cs_fall   = ~spi_s2_reg.cs_n & cs_d_reg;
  assign cs_rise   = spi_s2_reg.cs_n & ~cs_d_reg;

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  logic [15:0] sh_in_reg, sh_in_next, sh_out_reg, sh_out_next;
  logic [4:0]  bits_reg, bits_next;
  logic [5:0]  rd_idx_reg, rd_idx_next;
  logic        rd_pend_reg, rd_pend_next, out_diag_reg, out_diag_next;
  logic        miso_reg, miso_next;
  logic [15:0] rd_data;
  logic        frame_ok, wr_ev, spi_err, diag_clr;

  assign frame_ok = cs_rise & (bits_reg == `DSAM_FRAME_BITS);
  assign wr_ev    = frame_ok & sh_in_reg[15];
  assign spi_err  = cs_rise & (bits_reg != `DSAM_FRAME_BITS);
  assign diag_clr = frame_ok & out_diag_reg; // R7

  always_comb begin
    sh_in_next    = sh_in_reg;
    sh_out_next   = sh_out_reg;
    bits_next     = bits_reg;
    rd_idx_next   = rd_idx_reg;
    rd_pend_next  = rd_pend_reg;
    out_diag_next = out_diag_reg;
    miso_next     = miso_reg;
    if (cs_fall) begin
      bits_next     = 5'h00;
      sh_out_next   = rd_pend_reg ? rd_data : 16'h0000;
      out_diag_next = rd_pend_reg & (rd_idx_reg == `DSAM_IDX_DIAG);
    end else if (!spi_s2_reg.cs_n) begin
      if (sclk_rise) begin
        sh_in_next = {sh_in_reg[14:0], spi_s2_reg.mosi};
        bits_next  = bits_reg + 5'h01;
      end
      if (sclk_fall) begin
        miso_next   = sh_out_reg[15];
        sh_out_next = {sh_out_reg[14:0], 1'h0};
      end
    end
    if (frame_ok) begin
      rd_pend_next = ~sh_in_reg[15];
      if (!sh_in_reg[15])
        rd_idx_next = sh_in_reg[14:9];
    end
    if (cs_rise)
      out_diag_next = 1'h0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sh_in_reg    <= 16'h0000;
      sh_out_reg   <= 16'h0000;
      bits_reg     <= 5'h00;
      rd_idx_reg   <= 6'h00;
      rd_pend_reg  <= 1'h0;
      out_diag_reg <= 1'h0;
      miso_reg     <= 1'h0;
    end else begin
      sh_in_reg    <= sh_in_next;
      sh_out_reg   <= sh_out_next;
      bits_reg     <= bits_next;
      rd_idx_reg   <= rd_idx_next;
      rd_pend_reg  <= rd_pend_next;
      out_diag_reg <= out_diag_next;
      miso_reg     <= miso_next;
    end
  end

  // ----------------------------------------
  // Sample cycle divider
  // ----------------------------------------
  logic [31:0] base_reg, base_next;
  logic [7:0]  pcnt_reg, pcnt_next;
  logic [15:0] prd_reg;
  logic        base_wrap, tick;

  assign base_wrap = base_reg == 32'(BASE_CYCLES - 1);
  assign tick      = base_wrap & (pcnt_reg >= prd_reg[7:0]);

  always_comb begin
    base_next = base_wrap ? 32'h0 : base_reg + 32'h1;
    pcnt_next = tick ? 8'h00 : (base_wrap ? pcnt_reg + 8'h01 : pcnt_reg);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      base_reg <= 32'h0;
      pcnt_reg <= 8'h00;
    end else begin
      base_reg <= base_next;
      pcnt_reg <= pcnt_next;
    end
  end

  // ----------------------------------------
  // Configuration registers and test engine
  // ----------------------------------------
  logic [15:0] msc_reg, msc_next, prd_next, avg_reg, avg_next, actl_reg, actl_next;
  logic [15:0] mag_reg [2];
  logic [15:0] mag_next [2];
  logic [15:0] smp_reg [2];
  logic [15:0] smp_next [2];
  dsam_test_t  st_reg, st_next;
  logic [FLASH_AW:0] idx_reg, idx_next;
  logic [15:0] acc_reg, acc_next, sum;
  logic [31:0] tcnt_reg, tcnt_next;
  logic        mem_done, mem_fail, st_done;

  always_comb begin
    msc_next  = msc_reg;
    prd_next  = prd_reg;
    avg_next  = avg_reg;
    actl_next = actl_reg;
    mag_next  = mag_reg;
    smp_next  = smp_reg;
    st_next   = st_reg;
    idx_next  = idx_reg;
    acc_next  = acc_reg;
    tcnt_next = tcnt_reg;
    mem_done  = 1'h0;
    mem_fail  = 1'h0;
    st_done   = 1'h0;
    sum       = acc_reg + ((idx_reg != '0) ? flash_data : 16'h0000);
    if (wr_ev) begin
      unique case (sh_in_reg[14:9])
        `DSAM_IDX_MSC:  msc_next  = put_byte(msc_reg, sh_in_reg[8], sh_in_reg[7:0]); // R3 R4 R5
        `DSAM_IDX_PRD:  prd_next  = put_byte(prd_reg, sh_in_reg[8], sh_in_reg[7:0]);
        `DSAM_IDX_AVG:  avg_next  = put_byte(avg_reg, sh_in_reg[8], sh_in_reg[7:0]);
        `DSAM_IDX_ACTL: actl_next = put_byte(actl_reg, sh_in_reg[8], sh_in_reg[7:0]);
        `DSAM_IDX_MAG1: mag_next[0] = put_byte(mag_reg[0], sh_in_reg[8], sh_in_reg[7:0])
                                      & `DSAM_MAG_MASK; // R17
        `DSAM_IDX_MAG2: mag_next[1] = put_byte(mag_reg[1], sh_in_reg[8], sh_in_reg[7:0])
                                      & `DSAM_MAG_MASK; // R17
        `DSAM_IDX_SMP1: smp_next[0] = put_byte(smp_reg[0], sh_in_reg[8], sh_in_reg[7:0])
                                      & `DSAM_SMP_MASK; // R19
        `DSAM_IDX_SMP2: smp_next[1] = put_byte(smp_reg[1], sh_in_reg[8], sh_in_reg[7:0])
                                      & `DSAM_SMP_MASK; // R19
        default: ;
      endcase
    end
    unique case (st_reg)
      TS_IDLE: begin
        idx_next  = '0;
        acc_next  = 16'h0000;
        tcnt_next = 32'h0;
        if (msc_reg[`DSAM_MSC_MEM])
          st_next = TS_MEM; // R5
        else if (msc_reg[`DSAM_MSC_SELF])
          st_next = TS_SELF;
      end
      TS_MEM: begin
        acc_next = sum;
        if (idx_reg == (FLASH_AW+1)'(NW)) begin
          mem_done = 1'h1;
          mem_fail = sum != 16'h0000; // R6
          msc_next[`DSAM_MSC_MEM] = 1'h0; // R21
          st_next = TS_IDLE;
        end else
          idx_next = idx_reg + 1'b1;
      end
      TS_SELF: begin
        if (tcnt_reg == 32'(SELFTEST_CYCLES - 1)) begin
          st_done = 1'h1;
          msc_next[`DSAM_MSC_SELF] = 1'h0; // R20
          st_next = TS_IDLE;
        end else
          tcnt_next = tcnt_reg + 32'h1;
      end
      default: st_next = TS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      msc_reg  <= `DSAM_RST_MSC;
      prd_reg  <= `DSAM_RST_PRD;
      avg_reg  <= `DSAM_RST_AVG;
      actl_reg <= `DSAM_RST_ZERO;
      mag_reg  <= '{`DSAM_RST_ZERO, `DSAM_RST_ZERO};
      smp_reg  <= '{`DSAM_RST_ZERO, `DSAM_RST_ZERO};
      st_reg   <= TS_IDLE;
      idx_reg  <= '0;
      acc_reg  <= 16'h0000;
      tcnt_reg <= 32'h0;
    end else begin
      msc_reg  <= msc_next;
      prd_reg  <= prd_next;
      avg_reg  <= avg_next;
      actl_reg <= actl_next;
      mag_reg  <= mag_next;
      smp_reg  <= smp_next;
      st_reg   <= st_next;
      idx_reg  <= idx_next;
      acc_reg  <= acc_next;
      tcnt_reg <= tcnt_next;
    end
  end

  // ----------------------------------------
  // Alarm comparators
  // ----------------------------------------
  logic [13:0] ref_reg [2];
  logic [13:0] ref_next [2];
  logic [7:0]  acnt_reg [2];
  logic [7:0]  acnt_next [2];
  logic [1:0]  act_reg, act_next;

  always_comb begin
    logic [3:0]  sel;
    logic [13:0] v;
    sel       = 4'h0;
    v         = 14'h0;
    ref_next  = ref_reg;
    acnt_next = acnt_reg;
    act_next  = act_reg;
    for (int i = 0; i < 2; i++) begin // R15
      sel = i[0] ? actl_reg[15:12] : actl_reg[11:8]; // R22
      v   = alarm_src[sel];
      if (tick) begin // R24
        if (sel == 4'h0 || sel > `DSAM_SRC_LAST) begin
          act_next[i]  = 1'h0;
          acnt_next[i] = 8'h00;
        end else if (actl_reg[`DSAM_ACTL_ROC + i]) begin
          // Zero and one both give a one-sample period
          if (acnt_reg[i] + 8'h01 >= smp_reg[i][7:0]) begin // R18 R19
            act_next[i]  = hit(sx(v) - sx(ref_reg[i]), mag_reg[i]);
            ref_next[i]  = v;
            acnt_next[i] = 8'h00;
          end else
            acnt_next[i] = acnt_reg[i] + 8'h01;
        end else begin
          act_next[i] = hit(sx(v), mag_reg[i]); // R16
          ref_next[i] = v;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_reg  <= '{14'h0, 14'h0};
      acnt_reg <= '{8'h00, 8'h00};
      act_reg  <= 2'h0;
    end else begin
      ref_reg  <= ref_next;
      acnt_reg <= acnt_next;
      act_reg  <= act_next;
    end
  end

  // ----------------------------------------
  // Diagnostic flag word
  // ----------------------------------------
  logic [15:0] flags_reg, flags_next, fset, fclr;

  always_comb begin
    fset = 16'h0000;
    fclr = diag_clr ? 16'hFFFF : 16'h0000; // R7
    if (tick) begin // R8
      fset[`DSAM_DG_STERR] = cond_s2_reg.selftest_err; // R12
      fset[`DSAM_DG_OVR]   = cond_s2_reg.overrange;
      fset[`DSAM_DG_UPD]   = cond_s2_reg.flash_upd_fail;
      fset[`DSAM_DG_HIGH]  = cond_s2_reg.supply_high; // R13
      fset[`DSAM_DG_LOW]   = cond_s2_reg.supply_low; // R14
    end
    fset[`DSAM_DG_SPI]   = spi_err; // R12
    fset[`DSAM_DG_FLASH] = mem_done & mem_fail; // R6
    if (st_done)
      fset[15:10] = {cond_s2_reg.accel_fail, cond_s2_reg.gyro_fail}; // R10 R20
    fclr[`DSAM_DG_HIGH] = fclr[`DSAM_DG_HIGH] | ~cond_s2_reg.supply_high; // R9
    fclr[`DSAM_DG_LOW]  = fclr[`DSAM_DG_LOW] | ~cond_s2_reg.supply_low; // R9
    // Set beats clear so an error landing on the read is kept
    flags_next = ((flags_reg & ~fclr) | fset) & `DSAM_DIAG_KEEP; // R23
  end

  always_ff @(posedge clk) begin
    if (reset)
      flags_reg <= 16'h0000;
    else
      flags_reg <= flags_next;
  end

  // ----------------------------------------
  // Read mux and outputs
  // ----------------------------------------
  always_comb begin
    unique case (rd_idx_reg)
      `DSAM_IDX_DIAG: rd_data = flags_reg | {6'h00, act_reg, 8'h00}; // R11
      `DSAM_IDX_MSC:  rd_data = msc_reg;
      `DSAM_IDX_PRD:  rd_data = prd_reg;
      `DSAM_IDX_AVG:  rd_data = avg_reg;
      `DSAM_IDX_ACTL: rd_data = actl_reg;
      `DSAM_IDX_MAG1: rd_data = mag_reg[0];
      `DSAM_IDX_MAG2: rd_data = mag_reg[1];
      `DSAM_IDX_SMP1: rd_data = smp_reg[0];
      `DSAM_IDX_SMP2: rd_data = smp_reg[1];
      default:        rd_data = 16'h0000;
    endcase
  end

  assign spi_miso   = miso_reg;
  assign flash_addr = idx_reg[FLASH_AW-1:0];
  assign stim       = dsam_stim_t'({msc_reg[`DSAM_MSC_SELF], msc_reg[`DSAM_MSC_NEG],
                                    msc_reg[`DSAM_MSC_POS]}); // R3 R4

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_msc_hi_write(logic [1:0] b);
    wr_ev && sh_in_reg[14:9] == `DSAM_IDX_MSC && sh_in_reg[8] && sh_in_reg[1:0] == b;
  endsequence
  sequence s_mem_end;
    st_reg == TS_MEM && idx_reg == (FLASH_AW+1)'(NW);
  endsequence

  AST_NEG_STIM: assert property (s_msc_hi_write(2'h2) |=> stim.neg && !stim.pos) // R3
    else $error("negative stimulus not applied");
  AST_POS_STIM: assert property (s_msc_hi_write(2'h1) |=> stim.pos && !stim.neg) // R4
    else $error("positive stimulus not applied");
  AST_MEM_START: assert property (st_reg == TS_IDLE && msc_reg[11] |=> st_reg == TS_MEM) // R5
    else $error("memory test did not start");
  AST_MEM_RESULT: assert property ((s_mem_end and sum != 16'h0000) |=> flags_reg[6]) // R6
    else $error("checksum result not reported");
  AST_MEM_SELFCLR: assert property (s_mem_end and !wr_ev |=> !msc_reg[11] && st_reg == TS_IDLE) // R21
    else $error("memory test bit not cleared");
  AST_READ_CLEAR: assert property (diag_clr && !st_done |=> flags_reg[15:10] == 6'h00) // R7
    else $error("flags not cleared by read");
  AST_SET_WINS: assert property (diag_clr && tick && cond_s2_reg.overrange |=> flags_reg[4]) // R23
    else $error("new error lost on clearing read");
  AST_SPI_ERR: assert property (spi_err |=> flags_reg[3]) // R12
    else $error("short frame not flagged");
  AST_SUPPLY_AUTO: assert property (!cond_s2_reg.supply_high |=> !flags_reg[1]) // R9
    else $error("supply flag did not self-clear");
  AST_SUPPLY_LOW: assert property (tick && cond_s2_reg.supply_low |=> flags_reg[0]) // R14
    else $error("low supply not flagged");
  AST_SELF_DONE: assert property (st_done |=> !msc_reg[10] && st_reg == TS_IDLE) // R20
    else $error("self-test bit not cleared");
endmodule // dsam_monitor

//--- dsam_host.sv
`timescale 1ns/1ps
module dsam_host
  import dsam_pkg::*;
#(
  // Uneven halves of one 125 ns period keep every change on a falling clk edge
  parameter real LOW_NS  = 60.0,
  parameter real HIGH_NS = 65.0
) (
  // Serial lines
  output dsam_spi_in_t spi_out,
  input  wire logic    spi_miso
);
  // Clock idles high between frames, mode 3
  initial begin
    spi_out = 3'b110;
  end

  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  // Short frames only serve to provoke the framing error flag
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_out.cs_n = 1'b0;
    #HIGH_NS;
    for (int i = 15; i > 15 - nbits; i--) begin
      spi_out.sclk = 1'b0;
      spi_out.mosi = tx[i];
      #LOW_NS;
      spi_out.sclk = 1'b1;
      rx[i] = spi_miso;
      #HIGH_NS;
    end
    spi_out.cs_n = 1'b1;
    // Released line shows the inverse, never a stale copy
    spi_out.mosi = ~spi_out.mosi;
    #100;
  endtask
endmodule // dsam_host

//--- dsam_monitor_tb.sv
`timescale 1ns/1ps
module dsam_monitor_tb
  import dsam_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [6:0]  MISC = 7'h34;
  localparam logic [6:0]  DIAG = 7'h3C;
  localparam logic [15:0] FLAG_EXP [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0020};
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  dsam_spi_in_t      spi_bus;
  logic              spi_miso;
  dsam_cond_t        cond = '0;
  logic [15:0][13:0] alarm_src = '0;
  logic [5:0]        flash_addr;
  logic [15:0]       flash_data = 16'h0000;
  logic [15:0]       flash_mem [64];
  dsam_stim_t        stim;
  logic [15:0]       rx;
  logic              ramp = 1'b0;
  int                error_cnt = 0;
  int                checks = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) flash_data <= flash_mem[flash_addr];
  // Source five climbs one step per clock, 40 per sample cycle
  always @(negedge clk) if (ramp) alarm_src[5] <= alarm_src[5] + 14'h0001;

  dsam_monitor #(
    .BASE_CYCLES     (20),
    .SELFTEST_CYCLES (10),
    .FLASH_AW        (6)
  ) i_dsam_monitor (
    .clk        (clk),
    .reset      (reset),
    .spi_in     (spi_bus),
    .spi_miso   (spi_miso),
    .cond       (cond),
    .alarm_src  (alarm_src),
    .flash_addr (flash_addr),
    .flash_data (flash_data),
    .stim       (stim)
  );

  dsam_host i_dsam_host (
    .spi_out  (spi_bus),
    .spi_miso (spi_miso)
  );

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_dsam_host.xfer({1'b1, a, d}, 16, r);
  endtask

  task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
    wr_byte(a | 7'h01, d[15:8]);
    wr_byte(a, d[7:0]);
  endtask

  // Read answer arrives in the following frame
  task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    i_dsam_host.xfer({1'b0, a, 8'h00}, 16, r);
    i_dsam_host.xfer(16'h0000, 16, d);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_word(a, d);
    chk(d, exp);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    foreach (flash_mem[k]) flash_mem[k] = 16'h0000;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    idle(5);
    for (int i = 0; i < 4; i++) begin
      rd_chk(7'h20 + 7'(2 * i), 16'h0000);
      wr_word(7'h20 + 7'(2 * i), 16'hFFFF);
      rd_chk(7'h20 + 7'(2 * i), (i < 2) ? 16'hBFFF : 16'h00FF);
    end
    // Manual stimulus sequence; settling waits shortened for simulation
    wr_byte(7'h36, 8'h01);
    wr_byte(7'h39, 8'h04);
    wr_byte(7'h38, 8'h02);
    idle(50);
    wr_byte(7'h35, 8'h02);
    chk({13'h0000, stim}, 16'h0002);
    wr_byte(7'h35, 8'h01);
    chk({13'h0000, stim}, 16'h0001);
    wr_byte(7'h35, 8'h00);
    chk({13'h0000, stim}, 16'h0000);
    // Automatic self-test latches per-sensor failures
    cond = dsam_cond_t'(11'h420);
    wr_byte(7'h35, 8'h04);
    idle(50);
    rd_chk(MISC, 16'h0006);
    rd_chk(DIAG, 16'h8400);
    cond = '0;
    // Checksum test, passing then failing flash
    wr_byte(7'h35, 8'h08);
    idle(100);
    rd_chk(MISC, 16'h0006);
    rd_chk(DIAG, 16'h0000);
    flash_mem[5] = 16'h0001;
    wr_byte(7'h35, 8'h08);
    idle(100);
    rd_chk(DIAG, 16'h0040);
    rd_chk(DIAG, 16'h0000);
    // Error flags: set, persist, clear
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      cond = dsam_cond_t'(11'h001 << i);
      idle(100);
      rd_chk(DIAG, FLAG_EXP[i]);
      rd_chk(DIAG, FLAG_EXP[i]);
      @(negedge clk);
      cond = '0;
      idle(100);
      rd_word(DIAG, rx);
      if (i < 2) chk(rx, 16'h0000);
      rd_chk(DIAG, 16'h0000);
    end
    // Truncated frame is refused and flagged
    i_dsam_host.xfer(16'hFF00, 8, rx);
    rd_chk(DIAG, 16'h0008);
    rd_chk(DIAG, 16'h0000);
    // Two independent alarms, opposite directions
    @(negedge clk);
    alarm_src[2] = 14'h0064;
    alarm_src[3] = 14'h0064;
    wr_word(7'h20, 16'h8032);
    wr_word(7'h22, 16'h0032);
    wr_word(7'h28, 16'h3200);
    idle(100);
    rd_chk(DIAG, 16'h0100);
    rd_chk(DIAG, 16'h0100);
    @(negedge clk);
    alarm_src[3] = 14'h3FF6;
    idle(100);
    rd_chk(DIAG, 16'h0300);
    @(negedge clk);
    alarm_src[2] = 14'h000A;
    idle(100);
    rd_chk(DIAG, 16'h0200);
    // Rate of change on alarm one: 40 per sample stays under 60, 80 over two goes above
    wr_word(7'h20, 16'h803C);
    ramp = 1'b1;
    wr_byte(7'h24, 8'h00);
    wr_byte(7'h29, 8'h35);
    wr_byte(7'h28, 8'h40);
    idle(100);
    rd_chk(DIAG, 16'h0200);
    wr_byte(7'h24, 8'h02);
    idle(200);
    rd_chk(DIAG, 16'h0300);
    wr_byte(7'h24, 8'h01);
    idle(200);
    rd_chk(DIAG, 16'h0200);
    stop_test();
  end

  // Run needs about 53000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule // dsam_monitor_tb
